//--- mig_defs.vh
`ifndef MIG_DEFS_VH
`define MIG_DEFS_VH

// register offsets
`define MIG_CFG1_ADR 8'h00
`define MIG_PINSEL_ADR 8'h01
`define MIG_DIV03_ADR 8'h02
`define MIG_DIV47_ADR 8'h03
`define MIG_CFG3_ADR 8'h05
`define MIG_DIRPOL_A_ADR 8'h08
`define MIG_DIRPOL_B_ADR 8'h09
`define MIG_DIRPOL_C_ADR 8'h0a
`define MIG_DIRPOL_D_ADR 8'h0b
`define MIG_MASK1_ADR 8'h18
`define MIG_MASK2_ADR 8'h19
`define MIG_MASK3_ADR 8'h1a
`define MIG_MASK4_ADR 8'h1b
`define MIG_PMASK_LO_ADR 8'h1c
`define MIG_PMASK_HI_ADR 8'h1d
`define MIG_STAT1_ADR 8'h20
`define MIG_STAT2_ADR 8'h21
`define MIG_STAT3_ADR 8'h22
`define MIG_STAT4_ADR 8'h23
`define MIG_PSTAT_LO_ADR 8'h24
`define MIG_PSTAT_HI_ADR 8'h25
`define MIG_FANVAL_BASE 8'h38
`define MIG_FANLIM_BASE 8'h60

// field positions
`define MIG_CFG1_MON 0
`define MIG_CFG1_INTEN 1
`define MIG_CFG1_INTCLR 2
`define MIG_CFG1_AFC 7
`define MIG_CFG3_PIN16 0
`define MIG_CFG3_CICLR 1
`define MIG_CFG3_P16DIR 6
`define MIG_CFG3_P16POL 7
`define MIG_ST4_TEMP 0
`define MIG_ST4_THERMAL_ALARM_PIN 3
`define MIG_ST4_AFC 4
`define MIG_ST4_CASE 6
`define MIG_ST4_PIN16 7

// reset values
`define MIG_DIV_RST 8'h55
`define MIG_REG_RST 8'h00

// timing counts
`define MIG_FAN_TIMEOUT 8'hff
`define MIG_FAN_LAST_BEFORE 8'hfe
`define MIG_LOCAL_REARM 2'h2

`endif

//--- mig_core.v
// Contract
// - fan channels measured in order 0 to 7
// - abandon fan measurement when counter reaches 255
// - logic-mode fan slot times out after 255
// - channel bounded by 509 prescaled pulses
// - fan and analog cycles start together
// - case-open high latches status bit 6
// - case-open flag cleared by clear bit
// - case-open captured unpowered, interrupt on power
// - pin select bit chooses logic or fan
// - config three bit 0 selects pin sixteen
// - direction bit one means output
// - polarity bit one means active high
// - input status reflects asserted pin level
// - output status bit drives asserted level
// - mask bits hide pins; outputs auto-masked except pin 16
// - interrupt output active low, else released
// - out of limit: above high, at/below low
// - analog status rewritten each comparison
// - unmasked analog status sets analog latch
// - analog latch blocked for two local temps
// - fan start/stop gives one-off interrupt
// - thermal change gives one-off interrupt
// - output enabled when enable set, clear low
// - clear by status read, alert, clear bit (only a read of status register 1 clears here)
// - fan over limit sets fan status, latch
// - pin and case interrupts are not latched
`timescale 1ns/10ps
`include "mig_defs.vh"

module mig_core #(
    parameter ANA_CH = 16,
    parameter FAN_CH = 8,
    parameter NPIN = 17
) (
    input wire CORE_CLK,
    input wire SYS_RST,
    input wire CLK_EN,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    input wire ARA_HIT,
    input wire OSC_TICK,
    input wire ANA_VALID,
    input wire [3:0] ANA_CHAN,
    input wire [7:0] ANA_VALUE,
    input wire [7:0] ANA_HIGH_LIM,
    input wire [7:0] ANA_LOW_LIM,
    input wire LOCAL_TEMP_DONE,
    input wire THERMAL_ALARM_PIN_ACTIVE,
    input wire [2:0] THERMAL_ALARM_PIN_CHAN,
    input wire AUTO_FAN_EVENT,
    input wire CASE_OPEN_INPUT,
    input wire MAIN_PWR_GOOD,
    input wire [NPIN-1:0] PIN_IN,
    output reg [NPIN-1:0] PIN_OUT,
    output reg [NPIN-1:0] PIN_OE_N,
    output reg INT_OUT,
    output reg INT_OE_N,
    output reg MON_START
);

    reg [7:0] cfg1_q, pinsel_q, div03_q, div47_q, cfg3_q;
    reg [31:0] dirpol_q;
    reg [15:0] mask12_q, pmask_q;
    reg [7:0] mask3_q, mask4_q;
    reg [ANA_CH-1:0] ana_st_q;
    reg [FAN_CH-1:0] fan_st_q;
    reg [NPIN-1:0] pout_q, pin_d1_q;
    reg [7:0] fan_val [0:FAN_CH-1];
    reg [7:0] fan_lim [0:FAN_CH-1];
    reg thermal_alarm_pin_st_q, afc_st_q, case_q, thermal_alarm_pin_q;
    reg ana_lat_q, fan_lat_q, evt_lat_q, fan_blk_q;
    reg [1:0] rearm_q;
    reg [2:0] fch_q;
    reg fph_q, fedge_q, frun_q;
    reg [7:0] fcnt_q;
    reg [2:0] pre_q;
    wire wr = CLK_EN & REG_WR;
    wire rd = CLK_EN & REG_RD;
    integer i, j;

    // pin k: direction bit 2k, polarity bit 2k+1; pin 16 lives in cfg3
    function pin_dir;
        input [4:0] k;
        begin
            if (k == 5'd16)
                pin_dir = cfg3_q[`MIG_CFG3_P16DIR];
            else
                pin_dir = dirpol_q[{k[3:0], 1'b0}];
        end
    endfunction

    function pin_pol;
        input [4:0] k;
        begin
            if (k == 5'd16)
                pin_pol = cfg3_q[`MIG_CFG3_P16POL];
            else
                pin_pol = dirpol_q[{k[3:0], 1'b1}];
        end
    endfunction

    // a pin is logic unless it is a fan input or the thermal pin
    function pin_is_logic;
        input [4:0] k;
        begin
            if (k == 5'd16)
                pin_is_logic = cfg3_q[`MIG_CFG3_PIN16];
            else if (k >= 5'd8)
                pin_is_logic = pinsel_q[k[2:0]];
            else
                pin_is_logic = 1'b1;
        end
    endfunction

    // status seen for each pin: outputs show written value, inputs asserted level, fan and thermal pins 0
    reg [NPIN-1:0] pstat;
    reg [NPIN-1:0] pirq;
    always @*
    begin
        pstat = {NPIN{1'b0}};
        pirq = {NPIN{1'b0}};
        for (i = 0; i < NPIN; i = i + 1)
        begin
            if (pin_is_logic(i[4:0]))
            begin
                if (pin_dir(i[4:0]))
                    pstat[i] = pout_q[i];
                else
                    pstat[i] = (pin_d1_q[i] == pin_pol(i[4:0]));
            end
            if (i == 16)
                pirq[i] = pstat[i] & ~mask4_q[`MIG_ST4_PIN16];
            else
                pirq[i] = pstat[i] & ~pmask_q[i] & ~pin_dir(i[4:0]);
        end
    end

    // clearing actions
    wire rd_st1 = rd & (REG_ADDR == `MIG_STAT1_ADR);
    wire int_clr = rd_st1 | (CLK_EN & ARA_HIT) |
        cfg1_q[`MIG_CFG1_INTCLR];

    // analog comparison
    wire ana_out = (ANA_VALUE > ANA_HIGH_LIM) |
        (ANA_VALUE <= ANA_LOW_LIM);
    wire ana_any = |(ana_st_q & ~mask12_q[ANA_CH-1:0]) |
        (thermal_alarm_pin_st_q & ~mask4_q[`MIG_ST4_TEMP]);

    // thermal alarm state and change
    wire thermal_alarm_pin_now = THERMAL_ALARM_PIN_ACTIVE & ~cfg3_q[`MIG_CFG3_PIN16];
    wire thermal_alarm_pin_chg = CLK_EN & (thermal_alarm_pin_now != thermal_alarm_pin_q);
    wire afc_evt = CLK_EN & AUTO_FAN_EVENT & cfg1_q[`MIG_CFG1_AFC];

    // fan sequencer
    wire [1:0] dsel = fch_q[2] ? div47_q[{fch_q[1:0], 1'b0} +: 2] :
        div03_q[{fch_q[1:0], 1'b0} +: 2];
    wire fgpio = pinsel_q[fch_q];
    wire [2:0] pre_top = fgpio ? 3'h0 : ((3'h1 << dsel) - 3'h1);
    wire pre_hit = OSC_TICK & (pre_q == pre_top);
    wire tach_rise = PIN_IN[8 + fch_q] & ~pin_d1_q[8 + fch_q] & ~fgpio;
    wire f_timeout = frun_q & pre_hit &
        (fcnt_q == `MIG_FAN_LAST_BEFORE);
    wire f_done = frun_q & ((fph_q & tach_rise & fedge_q) | f_timeout);
    wire [7:0] f_res = f_timeout ? `MIG_FAN_TIMEOUT : fcnt_q;
    wire cyc_end = CLK_EN & f_done & (fch_q == 3'h7);
    wire mon_rise = wr & (REG_ADDR == `MIG_CFG1_ADR) &
        REG_WDATA[`MIG_CFG1_MON] & ~cfg1_q[`MIG_CFG1_MON];

    always @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            frun_q <= 1'b0;
            fch_q <= 3'h0;
            fph_q <= 1'b0;
            fedge_q <= 1'b0;
            fcnt_q <= 8'h00;
            pre_q <= 3'h0;
            MON_START <= 1'b0;
        end
        else if (CLK_EN)
        begin
            MON_START <= mon_rise;
            if (mon_rise | (cyc_end & cfg1_q[`MIG_CFG1_MON]))
            begin
                frun_q <= 1'b1;
                fch_q <= 3'h0;
                fph_q <= 1'b0;
                fedge_q <= 1'b0;
                fcnt_q <= 8'h00;
                pre_q <= 3'h0;
            end
            else if (f_done)
            begin
                frun_q <= (fch_q != 3'h7);
                fch_q <= fch_q + 3'h1;
                fph_q <= 1'b0;
                fedge_q <= 1'b0;
                fcnt_q <= 8'h00;
                pre_q <= 3'h0;
            end
            else if (frun_q)
            begin
                if (tach_rise)
                begin
                    fedge_q <= ~fedge_q;
                    if (fedge_q)
                    begin
                        fph_q <= 1'b1;
                        fcnt_q <= 8'h00;
                    end
                end
                if (OSC_TICK)
                    pre_q <= pre_hit ? 3'h0 : pre_q + 3'h1;
                if (pre_hit & ~(tach_rise & fedge_q))
                    fcnt_q <= fcnt_q + 8'h01;
            end
        end
    end

    // fan results, memory without reset
    always @(posedge CORE_CLK)
    begin
        if (CLK_EN)
        begin
            if (f_done)
                fan_val[fch_q] <= f_res;
            if (wr & (REG_ADDR[7:3] == `MIG_FANLIM_BASE >> 3))
                fan_lim[REG_ADDR[2:0]] <= REG_WDATA;
        end
    end

    wire fan_over = f_res > fan_lim[fch_q];

    always @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            cfg1_q <= `MIG_REG_RST;
            pinsel_q <= `MIG_REG_RST;
            div03_q <= `MIG_DIV_RST;
            div47_q <= `MIG_DIV_RST;
            cfg3_q <= `MIG_REG_RST;
            dirpol_q <= 32'h0000_0000;
            mask12_q <= 16'h0000;
            mask3_q <= `MIG_REG_RST;
            mask4_q <= `MIG_REG_RST;
            pmask_q <= 16'h0000;
            pout_q <= {NPIN{1'b0}};
            pin_d1_q <= {NPIN{1'b0}};
            ana_st_q <= {ANA_CH{1'b0}};
            fan_st_q <= {FAN_CH{1'b0}};
            thermal_alarm_pin_st_q <= 1'b0;
            afc_st_q <= 1'b0;
            case_q <= 1'b0;
            thermal_alarm_pin_q <= 1'b0;
            ana_lat_q <= 1'b0;
            fan_lat_q <= 1'b0;
            evt_lat_q <= 1'b0;
            fan_blk_q <= 1'b0;
            rearm_q <= 2'h0;
            REG_RDATA <= 8'h00;
            PIN_OUT <= {NPIN{1'b0}};
            PIN_OE_N <= {NPIN{1'b1}};
            INT_OUT <= 1'b0;
            INT_OE_N <= 1'b1;
        end
        else if (CLK_EN)
        begin
            pin_d1_q <= PIN_IN;
            thermal_alarm_pin_q <= thermal_alarm_pin_now;
            if (wr)
            begin
                case (REG_ADDR)
                    `MIG_CFG1_ADR: cfg1_q <= REG_WDATA;
                    `MIG_PINSEL_ADR: pinsel_q <= REG_WDATA;
                    `MIG_DIV03_ADR: div03_q <= REG_WDATA;
                    `MIG_DIV47_ADR: div47_q <= REG_WDATA;
                    `MIG_CFG3_ADR: cfg3_q <= REG_WDATA;
                    `MIG_DIRPOL_A_ADR: dirpol_q[7:0] <= REG_WDATA;
                    `MIG_DIRPOL_B_ADR: dirpol_q[15:8] <= REG_WDATA;
                    `MIG_DIRPOL_C_ADR: dirpol_q[23:16] <= REG_WDATA;
                    `MIG_DIRPOL_D_ADR: dirpol_q[31:24] <= REG_WDATA;
                    `MIG_MASK1_ADR: mask12_q[7:0] <= REG_WDATA;
                    `MIG_MASK2_ADR: mask12_q[15:8] <= REG_WDATA;
                    `MIG_MASK3_ADR: mask3_q <= REG_WDATA;
                    `MIG_MASK4_ADR: mask4_q <= REG_WDATA;
                    `MIG_PMASK_LO_ADR: pmask_q[7:0] <= REG_WDATA;
                    `MIG_PMASK_HI_ADR: pmask_q[15:8] <= REG_WDATA;
                    `MIG_PSTAT_LO_ADR: pout_q[7:0] <= REG_WDATA;
                    `MIG_PSTAT_HI_ADR: pout_q[15:8] <= REG_WDATA;
                    `MIG_STAT4_ADR:
                        pout_q[16] <= REG_WDATA[`MIG_ST4_PIN16];
                    default: ;
                endcase
            end
            // analog status follows each comparison
            if (ANA_VALID)
                ana_st_q[ANA_CHAN] <= ana_out;
            if (THERMAL_ALARM_PIN_CHAN[2] & thermal_alarm_pin_chg)
                thermal_alarm_pin_st_q <= 1'b1;
            else if (ANA_VALID & (ANA_CHAN == 4'h2))
                thermal_alarm_pin_st_q <= ana_out;
            if (thermal_alarm_pin_chg)
            begin
                if (THERMAL_ALARM_PIN_CHAN[0])
                    ana_st_q[0] <= 1'b1;
                if (THERMAL_ALARM_PIN_CHAN[1])
                    ana_st_q[1] <= 1'b1;
            end
            // one-off event bit cleared at a fan cycle start or end
            if (afc_evt)
                afc_st_q <= 1'b1;
            else if (mon_rise | cyc_end)
                afc_st_q <= 1'b0;
            // case-open set wins over a held clear
            if (CASE_OPEN_INPUT)
                case_q <= 1'b1;
            else if (cfg3_q[`MIG_CFG3_CICLR])
                case_q <= 1'b0;
            if (f_done)
                fan_st_q[fch_q] <= fan_over;
            // analog latch with two-local-measurement blocking
            if (int_clr)
                rearm_q <= `MIG_LOCAL_REARM;
            else if (LOCAL_TEMP_DONE & (rearm_q != 2'h0))
                rearm_q <= rearm_q - 2'h1;
            if (ana_any & (rearm_q == 2'h0) & ~int_clr)
                ana_lat_q <= 1'b1;
            else if (int_clr)
                ana_lat_q <= 1'b0;
            // fan latch blocked until end of the monitoring cycle in progress (next cyc_end)
            if (int_clr)
                fan_blk_q <= 1'b1;
            else if (cyc_end)
                fan_blk_q <= 1'b0;
            if (|(fan_st_q & ~mask3_q) & ~fan_blk_q & ~int_clr)
                fan_lat_q <= 1'b1;
            else if (int_clr)
                fan_lat_q <= 1'b0;
            // one-off events: an edge sets, clearing drops it for good
            if ((thermal_alarm_pin_chg & ~mask4_q[`MIG_ST4_THERMAL_ALARM_PIN]) |
                (afc_evt & ~mask4_q[`MIG_ST4_AFC]))
                evt_lat_q <= 1'b1;
            else if (int_clr)
                evt_lat_q <= 1'b0;
            if (rd)
                REG_RDATA <= rd_mux(REG_ADDR);
            // open-drain pins: pull low when the wanted level is low
            for (j = 0; j < NPIN; j = j + 1)
            begin
                PIN_OUT[j] <= 1'b0;
                if (j == 16 & ~cfg3_q[`MIG_CFG3_PIN16])
                    PIN_OE_N[j] <= ~thermal_alarm_pin_now;
                else
                    PIN_OE_N[j] <= ~(pin_is_logic(j[4:0]) &
                        pin_dir(j[4:0]) &
                        (pout_q[j] != pin_pol(j[4:0])));
            end
            INT_OUT <= 1'b0;
            INT_OE_N <= ~(cfg1_q[`MIG_CFG1_INTEN] &
                ~cfg1_q[`MIG_CFG1_INTCLR] &
                (ana_lat_q | fan_lat_q | evt_lat_q | (|pirq) |
                (case_q & MAIN_PWR_GOOD &
                ~mask4_q[`MIG_ST4_CASE])));
        end
    end

    // status register four image
    wire [7:0] st4 = {pstat[16], case_q, 1'b0, afc_st_q,
        (thermal_alarm_pin_q ^ thermal_alarm_pin_now) | (evt_lat_q & thermal_alarm_pin_q), 2'b00, thermal_alarm_pin_st_q};

    function [7:0] rd_mux;
        input [7:0] a;
        begin
            case (a)
                `MIG_CFG1_ADR: rd_mux = cfg1_q;
                `MIG_PINSEL_ADR: rd_mux = pinsel_q;
                `MIG_DIV03_ADR: rd_mux = div03_q;
                `MIG_DIV47_ADR: rd_mux = div47_q;
                `MIG_CFG3_ADR: rd_mux = cfg3_q;
                `MIG_DIRPOL_A_ADR: rd_mux = dirpol_q[7:0];
                `MIG_DIRPOL_B_ADR: rd_mux = dirpol_q[15:8];
                `MIG_DIRPOL_C_ADR: rd_mux = dirpol_q[23:16];
                `MIG_DIRPOL_D_ADR: rd_mux = dirpol_q[31:24];
                `MIG_MASK1_ADR: rd_mux = mask12_q[7:0];
                `MIG_MASK2_ADR: rd_mux = mask12_q[15:8];
                `MIG_MASK3_ADR: rd_mux = mask3_q;
                `MIG_MASK4_ADR: rd_mux = mask4_q;
                `MIG_PMASK_LO_ADR: rd_mux = pmask_q[7:0];
                `MIG_PMASK_HI_ADR: rd_mux = pmask_q[15:8];
                `MIG_STAT1_ADR: rd_mux = ana_st_q[7:0];
                `MIG_STAT2_ADR: rd_mux = ana_st_q[15:8];
                `MIG_STAT3_ADR: rd_mux = fan_st_q;
                `MIG_STAT4_ADR: rd_mux = st4;
                `MIG_PSTAT_LO_ADR: rd_mux = pstat[7:0];
                `MIG_PSTAT_HI_ADR: rd_mux = pstat[15:8];
                default:
                begin
                    if (a[7:3] == `MIG_FANVAL_BASE >> 3)
                        rd_mux = fan_val[a[2:0]];
                    else if (a[7:3] == `MIG_FANLIM_BASE >> 3)
                        rd_mux = fan_lim[a[2:0]];
                    else
                        rd_mux = 8'h00;
                end
            endcase
        end
    endfunction

endmodule // mig_core

//--- mig_ext.sv
`timescale 1ns/10ps
module mig_ext (
    input wire [16:0] pin_oe_n,
    input wire [16:0] ext_low,
    input wire int_oe_n,
    output wire [16:0] pin_lvl,
    output wire int_lvl
);
    // open-drain wires with pull-ups: low when either side pulls
    assign pin_lvl = pin_oe_n & ~ext_low;
    assign int_lvl = int_oe_n;
endmodule // mig_ext

//--- mig_core_chk.sv
`timescale 1ns/10ps
`include "mig_defs.vh"
module mig_core_chk #(
    parameter NPIN = 17
) (
    input wire CORE_CLK,
    input wire SYS_RST,
    input wire CLK_EN,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_RDATA,
    input wire [NPIN-1:0] PIN_OUT,
    input wire [NPIN-1:0] PIN_OE_N,
    input wire INT_OUT,
    input wire INT_OE_N,
    input wire MON_START
);
    reg [7:0] cfg1_q;
    always @(posedge CORE_CLK)
    begin
        if (SYS_RST)
            cfg1_q <= `MIG_REG_RST;
        else if (CLK_EN && REG_WR && REG_ADDR == `MIG_CFG1_ADR)
            cfg1_q <= REG_WDATA;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    a_reset_release: assert property (
        $fell(SYS_RST) && $past(CLK_EN) |-> INT_OE_N && (&PIN_OE_N))
        else $error("outputs not released after reset");
    a_reset_hold: assert property (disable iff (1'b0)
        CLK_EN && SYS_RST |=> INT_OE_N && REG_RDATA == 8'h00 && !MON_START)
        else $error("outputs active during reset");
    a_open_drain: assert property (
        PIN_OUT == {NPIN{1'b0}} && !INT_OUT)
        else $error("open-drain output drives high");
    a_int_gate: assert property (
        CLK_EN && (!cfg1_q[`MIG_CFG1_INTEN] || cfg1_q[`MIG_CFG1_INTCLR])
        |=> INT_OE_N)
        else $error("interrupt asserted while disabled");
    a_mon_pulse: assert property (
        CLK_EN && MON_START |=> !MON_START)
        else $error("start pulse longer than one cycle");
    a_mon_cause: assert property (
        $rose(MON_START) |-> cfg1_q[`MIG_CFG1_MON])
        else $error("start pulse without monitor bit");
    a_cfg1_read: assert property (
        CLK_EN && REG_RD && REG_ADDR == `MIG_CFG1_ADR
        |=> REG_RDATA == $past(cfg1_q))
        else $error("config one reads back wrong");
    a_freeze_all: assert property (
        !CLK_EN |=> $stable(INT_OE_N) && $stable(PIN_OE_N)
        && $stable(REG_RDATA))
        else $error("state moved with clock enable low");
    a_rdata_hold: assert property (
        CLK_EN && !REG_RD |=> $stable(REG_RDATA))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (
        CLK_EN && REG_RD && REG_ADDR == 8'h7f |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
endmodule // mig_core_chk
bind mig_core mig_core_chk #(.NPIN(NPIN)) u_chk (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PIN_OUT(PIN_OUT),
    .PIN_OE_N(PIN_OE_N), .INT_OUT(INT_OUT), .INT_OE_N(INT_OE_N),
    .MON_START(MON_START));

//--- mig_core_test.sv
`timescale 1ns/10ps
`include "mig_defs.vh"
module mig_core_test;
    localparam S_ARA = 0, S_LTD = 1, S_AFE = 2, S_AV = 3;
    reg clk = 0, rst = 1, clk_en = 1, wr_s = 0, rd_s = 0, ara = 0, tick = 0;
    reg av = 0, ltd = 0, tha = 0, afe = 0, ci = 0, pg = 1;
    reg [7:0] addr = 8'h00, wdata = 8'h00, aval = 8'h00;
    reg [7:0] ahi = 8'h00, alo = 8'h00;
    reg [3:0] ach = 4'h0;
    reg [2:0] thc = 3'h0;
    reg [16:0] ext_low = 17'h0;
    wire [7:0] rdata;
    wire [16:0] pin_lvl, pin_out, pin_oe_n;
    wire int_out, int_oe_n, int_lvl, mon;
    integer err_count = 0, n_tests = 0, cyc = 0, i;
    always #20 clk = ~clk;
    always @(posedge clk) tick <= ~tick;
    mig_core u_dut (.CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(clk_en),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
        .REG_RDATA(rdata), .ARA_HIT(ara), .OSC_TICK(tick), .ANA_VALID(av),
        .ANA_CHAN(ach), .ANA_VALUE(aval), .ANA_HIGH_LIM(ahi),
        .ANA_LOW_LIM(alo), .LOCAL_TEMP_DONE(ltd), .THERMAL_ALARM_PIN_ACTIVE(tha),
        .THERMAL_ALARM_PIN_CHAN(thc), .AUTO_FAN_EVENT(afe), .CASE_OPEN_INPUT(ci),
        .MAIN_PWR_GOOD(pg), .PIN_IN(pin_lvl), .PIN_OUT(pin_out),
        .PIN_OE_N(pin_oe_n), .INT_OUT(int_out), .INT_OE_N(int_oe_n),
        .MON_START(mon));
    mig_ext u_ext (.pin_oe_n(pin_oe_n), .ext_low(ext_low),
        .int_oe_n(int_oe_n), .pin_lvl(pin_lvl), .int_lvl(int_lvl));
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp)
            begin
                err_count = err_count + 1;
                $display("unexpected %0t: saw %h not %h", $time, seen, exp);
            end
        end
    endtask
    task reg_wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr_s <= 1'b1;
            @(posedge clk);
            wr_s <= 1'b0;
        end
    endtask
    task reg_rd(input [7:0] a, input [7:0] exp);
        begin
            repeat (2) @(posedge clk);
            addr <= a;
            rd_s <= 1'b1;
            @(posedge clk);
            rd_s <= 1'b0;
            // read data launched one edge earlier, stable here
            @(posedge clk);
            chk(rdata, exp);
        end
    endtask
    task pul(input integer s);
        begin
            @(posedge clk);
            ara <= (s == S_ARA);
            ltd <= (s == S_LTD);
            afe <= (s == S_AFE);
            av <= (s == S_AV);
            @(posedge clk);
            {ara, ltd, afe, av} <= 4'h0;
        end
    endtask
    task ck_int(input e);
        begin
            repeat (3) @(posedge clk);
            chk({7'h00, int_lvl}, {7'h00, e});
        end
    endtask
    task ck_oe(input e);
        begin
            repeat (3) @(posedge clk);
            chk({7'h00, pin_oe_n[0]}, {7'h00, e});
        end
    endtask
    task results;
        begin
            $display("errors %0d of %0d checks", err_count, n_tests);
            if (err_count == 0 && n_tests > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            err_count = err_count + 1;
            results;
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
        reg_rd(`MIG_PINSEL_ADR, 8'h00);
        reg_rd(`MIG_CFG1_ADR, 8'h00);
        reg_rd(`MIG_DIV03_ADR, `MIG_DIV_RST);
        reg_rd(`MIG_CFG3_ADR, 8'h00);
        reg_rd(`MIG_DIRPOL_A_ADR, 8'h00);
        reg_rd(`MIG_MASK4_ADR, 8'h00);
        reg_rd(`MIG_PSTAT_LO_ADR, 8'h00);
        reg_rd(8'h7f, 8'h00);
        // pin 1 pulled low, active low input
        ext_low[1] <= 1'b1;
        reg_rd(`MIG_PSTAT_LO_ADR, 8'h02);
        reg_wr(`MIG_DIRPOL_A_ADR, 8'h02);
        reg_rd(`MIG_PSTAT_LO_ADR, 8'h03);
        // pin 0 as output, first active high then active low
        reg_wr(`MIG_DIRPOL_A_ADR, 8'h03);
        reg_wr(`MIG_PSTAT_LO_ADR, 8'h00);
        ck_oe(1'b0);
        reg_rd(`MIG_PSTAT_LO_ADR, 8'h02);
        reg_wr(`MIG_PSTAT_LO_ADR, 8'h01);
        ck_oe(1'b1);
        reg_wr(`MIG_DIRPOL_A_ADR, 8'h01);
        ck_oe(1'b0);
        reg_rd(`MIG_PSTAT_LO_ADR, 8'h03);
        ext_low[1] <= 1'b0;
        reg_wr(`MIG_CFG1_ADR, 8'h02);
        ck_int(1'b1);
        ext_low[1] <= 1'b1;
        ck_int(1'b0);
        reg_rd(`MIG_STAT1_ADR, 8'h00);
        ck_int(1'b0);
        reg_wr(`MIG_PMASK_LO_ADR, 8'h02);
        ck_int(1'b1);
        reg_wr(`MIG_PMASK_LO_ADR, 8'h00);
        reg_wr(`MIG_CFG1_ADR, 8'h06);
        ck_int(1'b1);
        reg_wr(`MIG_CFG1_ADR, 8'h02);
        ck_int(1'b0);
        ext_low[1] <= 1'b0;
        ck_int(1'b1);
        reg_wr(`MIG_PSTAT_LO_ADR, 8'h00);
        reg_wr(`MIG_DIRPOL_A_ADR, 8'h00);
        // case open while main power is off
        pg <= 1'b0;
        ci <= 1'b1;
        repeat (2) @(posedge clk);
        ci <= 1'b0;
        ck_int(1'b1);
        reg_rd(`MIG_STAT4_ADR, 8'h40);
        pg <= 1'b1;
        ck_int(1'b0);
        reg_wr(`MIG_CFG3_ADR, 8'h02);
        reg_wr(`MIG_CFG3_ADR, 8'h00);
        reg_rd(`MIG_STAT4_ADR, 8'h00);
        ck_int(1'b1);
        // earlier clears left the analog latch blocked
        pul(S_LTD);
        pul(S_LTD);
        // analog limits: high is exclusive, low is inclusive
        ahi <= 8'h80;
        alo <= 8'h10;
        aval <= 8'h80;
        pul(S_AV);
        ck_int(1'b1);
        aval <= 8'h10;
        pul(S_AV);
        ck_int(1'b0);
        reg_rd(`MIG_STAT1_ADR, 8'h01);
        ck_int(1'b1);
        pul(S_LTD);
        ck_int(1'b1);
        pul(S_LTD);
        ck_int(1'b0);
        aval <= 8'h50;
        pul(S_AV);
        pul(S_ARA);
        ck_int(1'b1);
        reg_rd(`MIG_STAT1_ADR, 8'h00);
        pul(S_LTD);
        pul(S_LTD);
        aval <= 8'h81;
        pul(S_AV);
        ck_int(1'b0);
        reg_wr(`MIG_CFG1_ADR, 8'h06);
        reg_wr(`MIG_CFG1_ADR, 8'h02);
        ck_int(1'b1);
        aval <= 8'h50;
        pul(S_AV);
        pul(S_LTD);
        pul(S_LTD);
        // one-off events from fan control and thermal alarm
        reg_wr(`MIG_CFG1_ADR, 8'h82);
        pul(S_AFE);
        ck_int(1'b0);
        pul(S_ARA);
        ck_int(1'b1);
        ck_int(1'b1);
        pul(S_LTD);
        pul(S_LTD);
        thc <= 3'h1;
        tha <= 1'b1;
        ck_int(1'b0);
        chk({7'h00, pin_oe_n[16]}, 8'h00);
        pul(S_ARA);
        ck_int(1'b1);
        // fan 0 without tach pulses, others in logic mode
        for (i = 0; i < 8; i = i + 1)
            reg_wr(`MIG_FANLIM_BASE + i, (i == 0) ? 8'h80 : 8'hff);
        reg_wr(`MIG_PINSEL_ADR, 8'hfe);
        reg_wr(`MIG_CFG1_ADR, 8'h01);
        i = 0;
        while (!mon && i < 8)
        begin
            @(posedge clk);
            i = i + 1;
        end
        chk({7'h00, mon}, 8'h01);
        repeat (5000) @(posedge clk);
        reg_rd(`MIG_FANVAL_BASE, `MIG_FAN_TIMEOUT);
        reg_rd(`MIG_STAT3_ADR, 8'h01);
        results;
    end
endmodule // mig_core_test
